// ---- inc/wgw_defines.svh ----
// What this block does
// - count write enable changes only when its guard is 0
// - guard bits always read back as 1
// - counter writes accepted only while count write enable set
// - control write enable changes only when its guard is 0
// - run and flag writable only with control write enable
// - run takes written value if guard 0, enable set
// - counter counts selected ticks while running, else holds
// - overflow sets the watchdog reset flag
// - flag cleared by writing 0 with guard 0, enabled
// - counter wraps ff to 00 and asserts chip reset
// - counter resets to 00
// - select picks prescaled clock or internal oscillator
// - select bits 7 to 4 ignore writes, read 1
// - chip reset held for 256 oscillator cycles
// - counter write loads value, counting continues from it
// - oscillator-clocked watchdog runs in every chip mode
`ifndef WGW_DEFINES_SVH
`define WGW_DEFINES_SVH

// ---------------------------------------------------------------
// register word indices (byte address is four times these)
// ---------------------------------------------------------------
`define WGW_IDX_CTRL 2'h0
`define WGW_IDX_COUNT 2'h1
`define WGW_IDX_CLKSEL 2'h2

// ---------------------------------------------------------------
// control/status field positions
// ---------------------------------------------------------------
`define WGW_BIT_CWE_GUARD 7
`define WGW_BIT_CWE 6
`define WGW_BIT_CTRLWE_GUARD 5
`define WGW_BIT_CTRLWE 4
`define WGW_BIT_RUN_GUARD 3
`define WGW_BIT_RUN 2
`define WGW_BIT_FLAG_GUARD 1
`define WGW_BIT_FLAG 0

// ---------------------------------------------------------------
// reset values and fixed read patterns
// ---------------------------------------------------------------
`define WGW_COUNT_RST 8'h00
`define WGW_COUNT_MAX 8'hff
`define WGW_CLKSEL_RST 4'hf
`define WGW_CLKSEL_HIGH 4'hf
`define WGW_SEL_PRESC_BIT 3
`define WGW_RST_OSC_CYCLES 9'h100
`define WGW_DIV_MIN_LOG2 6

`endif

// ---- inc/wgw_pkg.sv ----
package wgw_pkg;

  // avalon transaction phase, gray along idle -> answer
  typedef enum logic [1:0] {
    WGW_BUS_IDLE = 2'b00,
    WGW_BUS_ANSWER = 2'b01
  } wgw_bus_state_t;

  // stored half of the control/status register
  typedef struct packed {
    logic count_write_enable;
    logic ctrl_write_enable;
    logic run_bit;
    logic wdt_reset_flag;
  } wgw_ctrl_t;

  // one register write as seen by the register file
  typedef struct packed {
    logic wr_ctrl;
    logic wr_count;
    logic wr_clksel;
    logic [7:0] data;
  } wgw_wr_t;

endpackage

// ---- hdl/wgw_top.sv ----
// The Avalon-MM register port and the placing of the registers were decided locally.
`include "wgw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module wgw_top #(
  parameter int DIV_MIN_LOG2 = `WGW_DIV_MIN_LOG2,
  parameter int COUNT_W = 8
) (
  input wire logic REF_CLK, // 20 MHz system clock
  input wire logic RST, // external reset pin, async, high
  input wire logic OSC_CLK_IN, // internal oscillator, asynchronous
  input wire logic [1:0] AVS_ADDRESS, // word index
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [31:0] AVS_WRITEDATA, // write data, low byte used
  input wire logic [3:0] AVS_BYTEENABLE, // lane 0 must be set to write
  output logic [31:0] AVS_READDATA, // registered read data
  output logic AVS_WAITREQUEST, // low for the answer cycle
  output logic CHIP_RESET_OUT, // internal chip reset request
  output logic RUN_OUT // watchdog running
);

  // ---------------------------------------------------------------
  // local widths
  // ---------------------------------------------------------------
  localparam int PRESC_W = DIV_MIN_LOG2 + 7;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  wgw_pkg::wgw_bus_state_t bus_state_reg;
  wgw_pkg::wgw_bus_state_t bus_state_next;
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  wgw_pkg::wgw_ctrl_t ctrl_reg;
  wgw_pkg::wgw_ctrl_t ctrl_next;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic [3:0] clksel_reg;
  logic [3:0] clksel_next;
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;
  logic [8:0] hold_reg;
  logic [8:0] hold_next;
  logic chip_rst_reg;
  logic chip_rst_next;
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // true on the last system cycle of a 2**(base+idx) period
  function automatic logic div_tick(
    input logic [PRESC_W-1:0] presc,
    input logic [2:0] idx
  );
    logic [PRESC_W-1:0] mask;
    mask = PRESC_W'((64'h1 << (DIV_MIN_LOG2 + int'(idx))) - 64'h1);
    return (presc & mask) == mask;
  endfunction

  // gate one protected bit by its guard (guard bits never stored)
  function automatic logic guarded(
    input logic wr,
    input logic guard_val,
    input logic new_val,
    input logic old_val
  );
    return (wr && !guard_val) ? new_val : old_val;
  endfunction

  // ---------------------------------------------------------------
  // oscillator synchroniser
  // ---------------------------------------------------------------

  // three stages; an edge counts where stage two is high and stage three is still low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= OSC_CLK_IN;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  wire osc_tick = osc_s2_reg && !osc_s3_reg;

  // ---------------------------------------------------------------
  // avalon slave decode
  // ---------------------------------------------------------------

  // a request is answered in the cycle after it is seen, once
  wire bus_req = AVS_READ || AVS_WRITE;
  wire commit = (bus_state_reg == wgw_pkg::WGW_BUS_ANSWER) && AVS_WRITE;
  wire lane0 = AVS_BYTEENABLE[0];
  wire [7:0] wd = AVS_WRITEDATA[7:0];

  wgw_pkg::wgw_wr_t wr;
  assign wr.wr_ctrl = commit && lane0 && (AVS_ADDRESS == `WGW_IDX_CTRL);
  assign wr.wr_count = commit && lane0 && (AVS_ADDRESS == `WGW_IDX_COUNT);
  assign wr.wr_clksel = commit && lane0 && (AVS_ADDRESS == `WGW_IDX_CLKSEL);
  assign wr.data = wd;

  // bus phase sequencing
  always_comb begin
    bus_state_next = bus_state_reg;
    wait_next = 1'b1;
    unique case (bus_state_reg)
      wgw_pkg::WGW_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_next = wgw_pkg::WGW_BUS_ANSWER;
          wait_next = 1'b0;
        end
      end
      wgw_pkg::WGW_BUS_ANSWER: begin
        bus_state_next = wgw_pkg::WGW_BUS_IDLE;
      end
      default: begin
        bus_state_next = wgw_pkg::WGW_BUS_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------

  // guard positions read as one whatever was written
  wire [7:0] ctrl_rd = {
    1'b1,
    ctrl_reg.count_write_enable,
    1'b1,
    ctrl_reg.ctrl_write_enable,
    1'b1,
    ctrl_reg.run_bit,
    1'b1,
    ctrl_reg.wdt_reset_flag
  };
  wire [7:0] clksel_rd = {`WGW_CLKSEL_HIGH, clksel_reg};
  wire [7:0] count_rd = 8'(count_reg);

  // unmapped index reads as zero
  always_comb begin
    rdata_next = rdata_reg;
    if (bus_state_reg == wgw_pkg::WGW_BUS_IDLE && AVS_READ) begin
      unique case (AVS_ADDRESS)
        `WGW_IDX_CTRL: rdata_next = {24'h000000, ctrl_rd};
        `WGW_IDX_COUNT: rdata_next = {24'h000000, count_rd};
        `WGW_IDX_CLKSEL: rdata_next = {24'h000000, clksel_rd};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock select and prescaler
  // ---------------------------------------------------------------

  // free running so a freshly chosen rate needs no restart
  assign presc_next = presc_reg + PRESC_W'(1);

  // only the low nibble stores; the high nibble is constant
  assign clksel_next = wr.wr_clksel ? wr.data[3:0] : clksel_reg;

  // oscillator path never depends on any mode input
  wire presc_sel = clksel_reg[`WGW_SEL_PRESC_BIT];
  wire sel_tick = presc_sel ?
    div_tick(presc_reg, clksel_reg[2:0]) :
    osc_tick;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------

  wire cnt_wr_ok = wr.wr_count && ctrl_reg.count_write_enable;
  wire cnt_step = ctrl_reg.run_bit && sel_tick;
  wire cnt_at_max = count_reg == COUNT_W'(`WGW_COUNT_MAX);

  // a permitted write beats a tick in the same cycle, so no overflow
  wire overflow = cnt_step && cnt_at_max && !cnt_wr_ok;

  always_comb begin
    count_next = count_reg;
    if (cnt_wr_ok) begin
      count_next = COUNT_W'(wr.data);
    end else if (cnt_step) begin
      count_next = count_reg + COUNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // control/status register
  // ---------------------------------------------------------------

  // protected writes use the enable held before this write
  wire ctrl_ok = wr.wr_ctrl && ctrl_reg.ctrl_write_enable;

  always_comb begin
    ctrl_next.count_write_enable = guarded(
      wr.wr_ctrl,
      wr.data[`WGW_BIT_CWE_GUARD],
      wr.data[`WGW_BIT_CWE],
      ctrl_reg.count_write_enable);
    ctrl_next.ctrl_write_enable = guarded(
      wr.wr_ctrl,
      wr.data[`WGW_BIT_CTRLWE_GUARD],
      wr.data[`WGW_BIT_CTRLWE],
      ctrl_reg.ctrl_write_enable);
    ctrl_next.run_bit = guarded(
      ctrl_ok,
      wr.data[`WGW_BIT_RUN_GUARD],
      wr.data[`WGW_BIT_RUN],
      ctrl_reg.run_bit);
    ctrl_next.wdt_reset_flag = ctrl_reg.wdt_reset_flag;
    if (overflow) begin
      ctrl_next.wdt_reset_flag = 1'b1;
    end else if (ctrl_ok && !wr.data[`WGW_BIT_FLAG_GUARD]
                 && !wr.data[`WGW_BIT_FLAG]) begin
      ctrl_next.wdt_reset_flag = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // internal reset stretcher
  // ---------------------------------------------------------------

  // counts oscillator edges; a new overflow restarts the hold
  always_comb begin
    chip_rst_next = chip_rst_reg;
    hold_next = hold_reg;
    if (overflow) begin
      chip_rst_next = 1'b1;
      hold_next = 9'h000;
    end else if (chip_rst_reg && osc_tick) begin
      hold_next = hold_reg + 9'h001;
      if (hold_reg + 9'h001 == `WGW_RST_OSC_CYCLES) begin
        chip_rst_next = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------

  // bus side flops
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      bus_state_reg <= wgw_pkg::WGW_BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      bus_state_reg <= bus_state_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // the pin reset clears all four stored control bits, run and flag included
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= '0;
      count_reg <= COUNT_W'(`WGW_COUNT_RST);
      clksel_reg <= `WGW_CLKSEL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      clksel_reg <= clksel_next;
    end
  end

  // timing flops
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      presc_reg <= '0;
      hold_reg <= 9'h000;
      chip_rst_reg <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      hold_reg <= hold_next;
      chip_rst_reg <= chip_rst_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // all straight from flops
  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign CHIP_RESET_OUT = chip_rst_reg;
  assign RUN_OUT = ctrl_reg.run_bit;

endmodule

`default_nettype wire

// ---- verification/wgw_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// port checker for the write guarded watchdog
// ----------------------------------------
module wgw_chk (
  input wire logic REF_CLK, // system clock
  input wire logic RST, // async reset
  input wire logic OSC_CLK_IN, // oscillator
  input wire logic [1:0] AVS_ADDRESS, // word index
  input wire logic AVS_READ, // read
  input wire logic AVS_WRITE, // write
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // lanes
  input wire logic [31:0] AVS_READDATA, // read data
  input wire logic AVS_WAITREQUEST, // wait
  input wire logic CHIP_RESET_OUT, // chip reset
  input wire logic RUN_OUT // running
);
  logic [1:0] osc_reg;
  logic [9:0] osc_n_reg;
  // decoded answer cycles
  wire rd_ans = AVS_READ && !AVS_WAITREQUEST;
  wire ctl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 2'h0 && AVS_BYTEENABLE[0];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // oscillator rises counted while chip reset stands; two flops since it is asynchronous
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      osc_reg <= 2'h0;
      osc_n_reg <= 10'h0;
    end else begin
      osc_reg <= {osc_reg[0], OSC_CLK_IN};
      osc_n_reg <= !CHIP_RESET_OUT ? 10'h0 : osc_n_reg + {9'h0, osc_reg == 2'b01};
    end
  end
  a_answer_next: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered in the next cycle");
  a_answer_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer lasted more than one cycle");
  a_guard_ones: assert property (rd_ans && AVS_ADDRESS == 2'h0 |->
    AVS_READDATA[31:8] == 24'h0 && (AVS_READDATA[7:0] & 8'haa) == 8'haa)
    else $error("guard bits not read as one");
  a_sel_high: assert property (rd_ans && AVS_ADDRESS == 2'h2 |-> AVS_READDATA[7:4] == 4'hf)
    else $error("select upper bits not one");
  a_unmapped_zero: assert property (rd_ans && AVS_ADDRESS == 2'h3 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_run_by_write: assert property ($changed(RUN_OUT) |->
    $past(ctl_wr && !AVS_WRITEDATA[3]) && RUN_OUT == $past(AVS_WRITEDATA[2]))
    else $error("run changed without a guarded write");
  a_reset_hold: assert property ($rose(CHIP_RESET_OUT) |-> CHIP_RESET_OUT [*8])
    else $error("chip reset too short");
  a_reset_length: assert property ($fell(CHIP_RESET_OUT) |->
    osc_n_reg >= 10'h0fa && osc_n_reg <= 10'h104)
    else $error("chip reset length off");
  a_trip_running: assert property ($rose(CHIP_RESET_OUT) |-> $past(RUN_OUT) && RUN_OUT)
    else $error("overflow while stopped or run lost");
  cover property ($rose(CHIP_RESET_OUT));
  cover property ($rose(RUN_OUT));
  cover property (rd_ans && AVS_ADDRESS == 2'h1);
endmodule

bind wgw_top wgw_chk wgw_chk_i (.REF_CLK(REF_CLK), .RST(RST), .OSC_CLK_IN(OSC_CLK_IN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CHIP_RESET_OUT(CHIP_RESET_OUT), .RUN_OUT(RUN_OUT));

`default_nettype wire

// ---- verification/wgw_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// self-checking bench for the write guarded watchdog
// ----------------------------------------
module wgw_top_test;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic OSC_CLK_IN = 1'b0;
  logic [1:0] AVS_ADDRESS = 2'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, CHIP_RESET_OUT, RUN_OUT;
  int n_mismatch = 0;
  int compares = 0;
  int seed = 32'he8189a20;
  int i, n, p;
  logic cwe, cte, run, flag;
  logic [7:0] q, v, d, sel;
  logic [3:0] be;

  // clocks: oscillator period unrelated to the system clock
  always #25 REF_CLK = ~REF_CLK;
  always #87 OSC_CLK_IN = ~OSC_CLK_IN;

  wgw_top #(.DIV_MIN_LOG2(2), .COUNT_W(8)) wgw_top_i (.REF_CLK(REF_CLK), .RST(RST),
    .OSC_CLK_IN(OSC_CLK_IN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CHIP_RESET_OUT(CHIP_RESET_OUT), .RUN_OUT(RUN_OUT));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] ctl_exp();
    return {1'b1, cwe, 1'b1, cte, 1'b1, run, 1'b1, flag};
  endfunction

  task automatic chk(input logic ok, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] wd, input logic [3:0] b,
                     output logic [7:0] rd);
    n = 0;
    @(posedge REF_CLK);
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, wd};
    AVS_BYTEENABLE <= b;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    rd = AVS_READDATA[7:0];
    if (n >= 20) chk(1'b0, 8'h0, 8'h0);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  // control write; the enable before this write gates run and flag
  task automatic wctl(input logic [7:0] wd, input logic [3:0] b);
    bus(1'b1, 2'h0, wd, b, q);
    if (b[0]) begin
      if (cte && !wd[3]) run = wd[2];
      if (cte && !wd[1] && !wd[0]) flag = 1'b0;
      if (!wd[7]) cwe = wd[6];
      if (!wd[5]) cte = wd[4];
    end
  endtask

  task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0, 4'hf, q);
    chk(q === e, q, e);
  endtask

  task automatic do_reset();
    RST <= 1'b1;
    {cwe, cte, run, flag} = 4'h0;
    repeat (8) @(posedge REF_CLK);
    RST <= 1'b0;
  endtask

  // run for w cycles at select s; the count must land in lo..hi
  task automatic rate(input logic [7:0] s, input int w, input logic [7:0] lo, input logic [7:0] hi);
    bus(1'b1, 2'h2, s, 4'hf, q);
    rdchk(2'h2, {4'hf, s[3:0]});
    bus(1'b1, 2'h1, 8'h00, 4'hf, q);
    wctl(8'h66, 4'hf);
    repeat (w) @(posedge REF_CLK);
    wctl(8'h62, 4'hf);
    bus(1'b0, 2'h1, 8'h0, 4'hf, q);
    chk(q >= lo && q <= hi, q, lo);
  endtask

  // load near the top and let it overflow at divide by eight
  task automatic trip();
    bus(1'b1, 2'h2, 8'h09, 4'hf, q);
    wctl(8'h9a, 4'hf);
    wctl(8'h6a, 4'hf);
    bus(1'b1, 2'h1, 8'hfe, 4'hf, q);
    wctl(8'h66, 4'hf);
    for (n = 0; CHIP_RESET_OUT !== 1'b1 && n < 100; n++) @(posedge REF_CLK);
    chk(n < 30, n[7:0], 8'h1e);
    flag = 1'b1;
    bus(1'b0, 2'h1, 8'h0, 4'hf, q);
    chk(q <= 8'h01, q, 8'h00);
    rdchk(2'h0, ctl_exp());
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    rdchk(2'h0, 8'haa);
    rdchk(2'h1, 8'h00);
    rdchk(2'h2, 8'hff);
    bus(1'b1, 2'h3, 8'h5a, 4'hf, q);
    rdchk(2'h3, 8'h00);
    // random control bytes, some with lane zero off so they must be ignored
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      be = ($random(seed) & 3) != 0 ? 4'hf : 4'he;
      wctl(d, be);
      rdchk(2'h0, ctl_exp());
      chk(RUN_OUT === run, {7'h0, RUN_OUT}, {7'h0, run});
    end
    wctl(8'h9a, 4'hf);
    wctl(8'h22, 4'hf);
    bus(1'b0, 2'h1, 8'h0, 4'hf, v);
    bus(1'b1, 2'h1, 8'h55, 4'hf, q);
    rdchk(2'h1, v);
    wctl(8'h6a, 4'hf);
    bus(1'b1, 2'h1, 8'h5a, 4'hf, q);
    repeat (20) @(posedge REF_CLK);
    rdchk(2'h1, 8'h5a);
    // every prescaled code, then one oscillator code with a random high nibble
    for (i = 0; i < 8; i++) begin
      sel = $random(seed);
      p = 1 << (2 + i);
      rate({sel[7:4], 1'b1, i[2:0]}, 6 * p, 8'h05, 8'h07);
    end
    sel = $random(seed);
    rate({sel[7:4], 1'b0, sel[2:0]}, 200, 8'h37, 8'h3c);
    trip();
    chk(RUN_OUT === 1'b1, {7'h0, RUN_OUT}, 8'h01);
    for (n = 0; CHIP_RESET_OUT !== 1'b0 && n < 1500; n++) @(posedge REF_CLK);
    chk(n < 1500, n[7:0], 8'h00);
    do_reset();
    rdchk(2'h0, 8'haa);
    trip();
    wctl(8'h8a, 4'hf);
    wctl(8'hac, 4'hf);
    rdchk(2'h0, ctl_exp());
    wctl(8'h9a, 4'hf);
    wctl(8'hac, 4'hf);
    rdchk(2'h0, ctl_exp());
    tally_and_finish();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge REF_CLK);
    n_mismatch++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
